/* crtfr_dram_seq.sv */
// Row strobe, address mux, column strobe sequencer with output latch
`timescale 1ns/100ps
module crtfr_dram_seq import crtfr_pkg::*; #(
  parameter int DATA_W = 8
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic load_in,
  input wire logic [DATA_W-1:0] ram_data_in,
  output logic row_strobe_n_out,
  output logic address_mux_select_out,
  output logic address_mux_select_inv_out,
  output logic column_strobe_n_out,
  output logic latch_transparent_out,
  output logic [DATA_W-1:0] latch_data_out,
  output logic done_out
);

  typedef enum logic [2:0] {CRTFR_IDLE, CRTFR_ROW, CRTFR_MUX, CRTFR_COL, CRTFR_CLOSE} crtfr_seq_t;

  crtfr_seq_t state;
  crtfr_seq_t next_state;
  logic [DATA_W-1:0] next_latch_data;

  // ----------------------------------------------
  // Sequence
  // ----------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      CRTFR_IDLE: if (load_in) next_state = CRTFR_ROW;
      CRTFR_ROW: next_state = CRTFR_MUX;
      CRTFR_MUX: next_state = CRTFR_COL;
      CRTFR_COL: next_state = CRTFR_CLOSE;
      CRTFR_CLOSE: next_state = CRTFR_IDLE;
    endcase
    // Latch follows RAM while the inverted mux is high, then holds
    next_latch_data = address_mux_select_inv_out ? ram_data_in : latch_data_out;
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state <= CRTFR_IDLE;
      latch_data_out <= '0;
    end else begin
      state <= next_state;
      latch_data_out <= next_latch_data;
    end
  end

  // All strobes return high on the close step, ending the access
  assign row_strobe_n_out = !(state == CRTFR_ROW || state == CRTFR_MUX || state == CRTFR_COL);
  assign address_mux_select_out = !(state == CRTFR_MUX || state == CRTFR_COL);
  assign address_mux_select_inv_out = !address_mux_select_out;
  assign column_strobe_n_out = (state != CRTFR_COL);
  assign latch_transparent_out = address_mux_select_inv_out;
  assign done_out = (state == CRTFR_CLOSE);

endmodule : crtfr_dram_seq

/* crtfr_host_model.sv */
// Behavioural host processor that grants the shared memory bus
`timescale 1ns/100ps
module crtfr_host_model (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic bus_request_n_in,
  input wire logic [7:0] delay_in,
  output logic bus_grant_n_out = 1'b1
);
  logic [7:0] wait_count = 8'h00;

  // ----------------------------------------------
  // Grant after the current machine cycle
  // ----------------------------------------------
  // The delay input stands in for the rest of the machine cycle, so the
  // bench can try both a prompt and a slow host.
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      bus_grant_n_out <= 1'b1;
      wait_count <= 8'h00;
    end else if (bus_request_n_in) begin
      bus_grant_n_out <= 1'b1;
      wait_count <= 8'h00;
    end else if (wait_count >= delay_in) begin
      bus_grant_n_out <= 1'b0;
    end else begin
      wait_count <= wait_count + 8'h01;
    end
  end
endmodule : crtfr_host_model

/* crtfr_pkg.sv */
// Constants shared by the raster timing and row fetch logic
// Functional notes
// - Request bus on scan lines 6, 14
// - Generator drives low 12 address bits
// - Grant polarities steer latch, loads, buffer
// - Line rate clock rises four chars early
// - Load pulse three dots after char clock
// - Load then row, mux, column strobes
// - Latch transparent while inverted mux high
// - Inverted mux falling captures, holds byte
// - Byte written on delayed buffer clock fall
// - Increment address, next load nine dots
// - Address held, no writes before active video
// - Recirculate enable low on scan 14
// - Scan 14 loads characters, moves enhancements
// - 26 rows, 80 cells, 15x9 cells
// - 115 chars per line, 35 blanking
// - Hsync 16 chars early, 7 wide
// - Vertical blank after 390 active scans
// - 60 Hz: sync 0 late, 19 long
// - 50 Hz: sync 38 late, 64 long
// - Interrupt two scan lines before request
package crtfr_pkg;

  // ----------------------------------------------
  // Horizontal timing, in dots and characters
  // ----------------------------------------------
  localparam logic [3:0] DOTS_PER_CHAR = 4'h9;
  localparam logic [3:0] LOAD_DELAY_DOTS = 4'h3;
  localparam logic [6:0] CHARS_PER_LINE = 7'h73;
  localparam logic [6:0] HBLANK_CHARS = 7'h23;
  localparam logic [6:0] ACTIVE_CHARS = 7'h50;
  localparam logic [6:0] ACTIVE_START = HBLANK_CHARS;
  localparam logic [6:0] HSYNC_LEAD = 7'h10;
  localparam logic [6:0] HSYNC_WIDTH = 7'h07;
  localparam logic [6:0] LRC_LEAD = 7'h04;

  // ----------------------------------------------
  // Vertical timing, in scan lines
  // ----------------------------------------------
  localparam logic [3:0] SCANS_PER_ROW = 4'hf;
  localparam logic [4:0] ROWS_PER_FRAME = 5'h1a;
  localparam logic [8:0] ACTIVE_LINES = 9'h186;
  localparam logic [8:0] VS_DELAY_60 = 9'h000;
  localparam logic [8:0] VS_WIDTH_60 = 9'h013;
  localparam logic [8:0] VBLANK_60 = 9'h019;
  localparam logic [8:0] VS_DELAY_50 = 9'h026;
  localparam logic [8:0] VS_WIDTH_50 = 9'h040;
  localparam logic [8:0] VBLANK_50 = 9'h06c;

  // ----------------------------------------------
  // Fetch scheduling
  // ----------------------------------------------
  localparam logic [3:0] ENH_FETCH_SCAN = 4'h6;
  localparam logic [3:0] CHAR_FETCH_SCAN = 4'he;
  localparam logic [3:0] NMI_LEAD_SCANS = 4'h2;
  localparam int LOW_ADDR_BITS = 12;

endpackage : crtfr_pkg

/* crtfr_skid2.sv */
// Two-entry buffer between the fetch path and the line buffers
`timescale 1ns/100ps
module crtfr_skid2 import crtfr_pkg::*; #(
  parameter int WIDTH = 9
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);

  logic [WIDTH-1:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic next_wr_ptr;
  logic next_rd_ptr;
  logic [1:0] next_count;
  logic push;
  logic pop;

  always_comb begin
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    next_wr_ptr = push ? !wr_ptr : wr_ptr;
    next_rd_ptr = pop ? !rd_ptr : rd_ptr;
    next_count = count;
    if (push && !pop) next_count = count + 2'h1;
    else if (pop && !push) next_count = count - 2'h1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      mem[0] <= '0;
      mem[1] <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      if (push) mem[wr_ptr] <= in_data_in;
    end
  end

  assign in_ready_out = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out = mem[rd_ptr];

endmodule : crtfr_skid2

/* crtfr_video_timing.sv */
// Raster timing generator and row fetch controller
`timescale 1ns/100ps
module crtfr_video_timing import crtfr_pkg::*; #(
  parameter int DATA_W = 8
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic frame_50hz_in,
  input wire logic bus_grant_n_in,
  input wire logic [DATA_W-1:0] ram_data_in,
  input wire logic [15:0] row_start_addr_in,
  input wire logic row_start_load_in,
  input wire logic line_buffer_ready_in,
  output logic bus_request_n_out,
  output logic nmi_n_out,
  output logic [15:0] fetch_addr_out,
  output logic addr_drive_en_out,
  output logic grant_active_high_out,
  output logic grant_active_low_buffered_out,
  output logic ram_latch_output_en_out,
  output logic temp_buffer_recirculate_out,
  output logic line_rate_clock_n_out,
  output logic character_rate_clock_out,
  output logic row_strobe_n_out,
  output logic address_mux_select_out,
  output logic address_mux_select_inv_out,
  output logic column_strobe_n_out,
  output logic latch_transparent_out,
  output logic [DATA_W-1:0] ram_latch_data_out,
  output logic delayed_buffer_clock_out,
  output logic buffer_recirculate_enable_out,
  output logic line_buffer_valid_out,
  output logic [DATA_W-1:0] line_buffer_data_out,
  output logic line_buffer_is_char_out,
  output logic hblank_out,
  output logic hsync_out,
  output logic vblank_out,
  output logic vsync_out,
  output logic [3:0] scan_line_out,
  output logic [4:0] row_out
);

  localparam logic [6:0] HSYNC_START = CHARS_PER_LINE - 7'h01 - HSYNC_LEAD;
  localparam logic [6:0] LRC_START = ACTIVE_START - LRC_LEAD;

  // ----------------------------------------------
  // Helpers
  // ----------------------------------------------
  function automatic logic in_window(input logic [8:0] pos, input logic [8:0] first, input logic [8:0] len);
    in_window = (pos >= first) && (pos < first + len);
  endfunction : in_window

  function automatic logic is_fetch_scan(input logic [3:0] scan);
    is_fetch_scan = (scan == ENH_FETCH_SCAN) || (scan == CHAR_FETCH_SCAN);
  endfunction : is_fetch_scan

  // ----------------------------------------------
  // Raster counters
  // ----------------------------------------------
  logic [3:0] dot;
  logic [6:0] chr;
  logic [8:0] line;
  logic [3:0] scan;
  logic [4:0] row;
  logic [3:0] next_dot;
  logic [6:0] next_chr;
  logic [8:0] next_line;
  logic [3:0] next_scan;
  logic [4:0] next_row;
  logic next_hblank;
  logic next_hsync;
  logic next_vblank;
  logic next_vsync;
  logic char_end;
  logic line_end;
  logic [8:0] frame_lines;
  logic [8:0] vs_start;
  logic [8:0] vs_width;

  always_comb begin
    char_end = (dot == DOTS_PER_CHAR - 4'h1);
    line_end = char_end && (chr == CHARS_PER_LINE - 7'h01);
    // Frame rate option picks the vertical blank length
    frame_lines = ACTIVE_LINES + (frame_50hz_in ? VBLANK_50 : VBLANK_60);
    vs_start = ACTIVE_LINES + (frame_50hz_in ? VS_DELAY_50 : VS_DELAY_60);
    vs_width = frame_50hz_in ? VS_WIDTH_50 : VS_WIDTH_60;
    next_dot = char_end ? 4'h0 : dot + 4'h1;
    next_chr = chr;
    if (char_end) next_chr = (chr == CHARS_PER_LINE - 7'h01) ? 7'h00 : chr + 7'h01;
    next_line = line;
    next_scan = scan;
    next_row = row;
    if (line_end) begin
      // A rate change mid-frame must not strand the counter past the end
      if (line >= frame_lines - 9'h001) begin
        next_line = 9'h000;
        next_scan = 4'h0;
        next_row = 5'h00;
      end else begin
        next_line = line + 9'h001;
        if (line < ACTIVE_LINES - 9'h001) begin
          if (scan == SCANS_PER_ROW - 4'h1) begin
            next_scan = 4'h0;
            next_row = row + 5'h01;
          end else begin
            next_scan = scan + 4'h1;
          end
        end
      end
    end
    next_hblank = (next_chr < ACTIVE_START);
    next_hsync = in_window({2'b00, next_chr}, {2'b00, HSYNC_START}, {2'b00, HSYNC_WIDTH});
    next_vblank = (next_line >= ACTIVE_LINES);
    next_vsync = in_window(next_line, vs_start, vs_width);
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      dot <= 4'h0;
      chr <= 7'h00;
      line <= 9'h000;
      scan <= 4'h0;
      row <= 5'h00;
      hblank_out <= 1'b1;
      hsync_out <= 1'b0;
      vblank_out <= 1'b0;
      vsync_out <= 1'b0;
    end else begin
      dot <= next_dot;
      chr <= next_chr;
      line <= next_line;
      scan <= next_scan;
      row <= next_row;
      hblank_out <= next_hblank;
      hsync_out <= next_hsync;
      vblank_out <= next_vblank;
      vsync_out <= next_vsync;
    end
  end

  assign scan_line_out = scan;
  assign row_out = row;
  assign character_rate_clock_out = (dot < LOAD_DELAY_DOTS + 4'h1);

  // ----------------------------------------------
  // Grant decode and sequencer
  // ----------------------------------------------
  logic grant;
  logic seq_load;
  logic seq_done;
  logic buf_in_ready;
  logic push;
  logic lrc;

  assign grant = !bus_grant_n_in;
  assign grant_active_high_out = grant;
  assign grant_active_low_buffered_out = bus_grant_n_in;
  assign ram_latch_output_en_out = grant;
  assign addr_drive_en_out = grant;
  // Temporary enhancement buffer recirculates unless the bus is ours
  assign temp_buffer_recirculate_out = bus_grant_n_in;
  // A full buffer stalls the loads, so no fetched word is dropped
  assign seq_load = grant && lrc && (dot == LOAD_DELAY_DOTS) && buf_in_ready;

  crtfr_dram_seq #(.DATA_W(DATA_W)) u_seq (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .load_in(seq_load),
    .ram_data_in(ram_data_in),
    .row_strobe_n_out(row_strobe_n_out),
    .address_mux_select_out(address_mux_select_out),
    .address_mux_select_inv_out(address_mux_select_inv_out),
    .column_strobe_n_out(column_strobe_n_out),
    .latch_transparent_out(latch_transparent_out),
    .latch_data_out(ram_latch_data_out),
    .done_out(seq_done)
  );

  // ----------------------------------------------
  // Fetch control
  // ----------------------------------------------
  logic req;
  logic is_char;
  logic [15:0] row_start;
  logic [LOW_ADDR_BITS-1:0] addr_low;
  logic [15-LOW_ADDR_BITS:0] addr_high;
  logic [6:0] byte_cnt;
  logic nmi;
  logic recirc;
  logic next_req;
  logic next_lrc;
  logic next_is_char;
  logic [15:0] next_row_start;
  logic [LOW_ADDR_BITS-1:0] next_addr_low;
  logic [15-LOW_ADDR_BITS:0] next_addr_high;
  logic [6:0] next_byte_cnt;
  logic next_nmi;
  logic next_recirc;
  logic active_line;

  always_comb begin
    active_line = (line < ACTIVE_LINES);
    // Loads before active video are dummies: no write, no increment
    push = seq_done && (chr >= ACTIVE_START) && (byte_cnt < ACTIVE_CHARS);
    next_req = req;
    next_lrc = lrc;
    next_is_char = is_char;
    next_addr_low = addr_low;
    next_addr_high = addr_high;
    next_byte_cnt = byte_cnt;
    next_row_start = row_start_load_in ? row_start_addr_in : row_start;
    if (!req && active_line && is_fetch_scan(scan) && chr == 7'h00 && dot == 4'h0) begin
      next_req = 1'b1;
      next_is_char = (scan == CHAR_FETCH_SCAN);
      next_addr_low = row_start[LOW_ADDR_BITS-1:0];
      next_addr_high = row_start[15:LOW_ADDR_BITS];
      next_byte_cnt = 7'h00;
    end
    if (req && chr == LRC_START && dot == 4'h0) next_lrc = 1'b1;
    if (push) begin
      next_addr_low = addr_low + LOW_ADDR_BITS'(1);
      next_byte_cnt = byte_cnt + 7'h01;
      if (byte_cnt == ACTIVE_CHARS - 7'h01) begin
        next_req = 1'b0;
        next_lrc = 1'b0;
      end
    end
    next_nmi = active_line && chr == 7'h00 &&
      (scan == ENH_FETCH_SCAN - NMI_LEAD_SCANS || scan == CHAR_FETCH_SCAN - NMI_LEAD_SCANS);
    // Decoded from the next counters so the level lines up with scan 14 itself
    next_recirc = !(next_line < ACTIVE_LINES && next_scan == CHAR_FETCH_SCAN);
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      req <= 1'b0;
      lrc <= 1'b0;
      is_char <= 1'b0;
      row_start <= 16'h0000;
      addr_low <= '0;
      addr_high <= '0;
      byte_cnt <= 7'h00;
      nmi <= 1'b0;
      recirc <= 1'b1;
      delayed_buffer_clock_out <= 1'b1;
    end else begin
      req <= next_req;
      lrc <= next_lrc;
      is_char <= next_is_char;
      row_start <= next_row_start;
      addr_low <= next_addr_low;
      addr_high <= next_addr_high;
      byte_cnt <= next_byte_cnt;
      nmi <= next_nmi;
      recirc <= next_recirc;
      delayed_buffer_clock_out <= !push;
    end
  end

  assign bus_request_n_out = !req;
  assign line_rate_clock_n_out = lrc;
  assign nmi_n_out = !nmi;
  assign buffer_recirculate_enable_out = recirc;
  assign fetch_addr_out = {addr_high, addr_low};

  // ----------------------------------------------
  // Path to the line buffers
  // ----------------------------------------------
  logic [DATA_W:0] buf_out;

  crtfr_skid2 #(.WIDTH(DATA_W + 1)) u_buf (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .in_valid_in(push),
    .in_data_in({is_char, ram_latch_data_out}),
    .in_ready_out(buf_in_ready),
    .out_valid_out(line_buffer_valid_out),
    .out_data_out(buf_out),
    .out_ready_in(line_buffer_ready_in)
  );

  assign line_buffer_data_out = buf_out[DATA_W-1:0];
  assign line_buffer_is_char_out = buf_out[DATA_W];

  // ----------------------------------------------
  // Checks
  // ----------------------------------------------
  property p_req_scan;
    @(posedge ref_clk_in) disable iff (reset_in)
    $fell(bus_request_n_out) |-> is_fetch_scan(scan);
  endproperty
  a_req_scan: assert property (p_req_scan) else $error("request outside scan 6 or 14");

  property p_req_release;
    @(posedge ref_clk_in) disable iff (reset_in)
    push && byte_cnt == 7'h4f |=> bus_request_n_out;
  endproperty
  a_req_release: assert property (p_req_release) else $error("request held after last byte");

  property p_no_early_write;
    @(posedge ref_clk_in) disable iff (reset_in)
    !delayed_buffer_clock_out |-> !hblank_out;
  endproperty
  a_no_early_write: assert property (p_no_early_write) else $error("byte written in blanking");

  property p_load_timing;
    @(posedge ref_clk_in) disable iff (reset_in)
    seq_load |-> dot == 4'h3 && line_rate_clock_n_out && !bus_grant_n_in;
  endproperty
  a_load_timing: assert property (p_load_timing) else $error("load at wrong dot");

  property p_strobe_order;
    @(posedge ref_clk_in) disable iff (reset_in)
    seq_load |=> !row_strobe_n_out ##1 !address_mux_select_out ##1 !column_strobe_n_out ##1 column_strobe_n_out;
  endproperty
  a_strobe_order: assert property (p_strobe_order) else $error("strobe order wrong");

  property p_hblank_end;
    @(posedge ref_clk_in) disable iff (reset_in)
    $fell(hblank_out) |-> chr == 7'h23 && dot == 4'h0;
  endproperty
  a_hblank_end: assert property (p_hblank_end) else $error("active video starts at wrong char");

  property p_hsync;
    @(posedge ref_clk_in) disable iff (reset_in)
    $rose(hsync_out) |-> chr == 7'h62 ##62 hsync_out ##1 !hsync_out;
  endproperty
  a_hsync: assert property (p_hsync) else $error("hsync position or width wrong");

  property p_vblank;
    @(posedge ref_clk_in) disable iff (reset_in)
    $rose(vblank_out) |-> line == 9'h186;
  endproperty
  a_vblank: assert property (p_vblank) else $error("vblank not after 390 scans");

  property p_recirc;
    @(posedge ref_clk_in) disable iff (reset_in)
    !buffer_recirculate_enable_out |-> scan == 4'he && !vblank_out;
  endproperty
  a_recirc: assert property (p_recirc) else $error("recirculate dropped off scan 14");

  property p_lrc_rise;
    @(posedge ref_clk_in) disable iff (reset_in)
    $rose(line_rate_clock_n_out) |-> chr == 7'h1f;
  endproperty
  a_lrc_rise: assert property (p_lrc_rise) else $error("line rate clock not four chars early");

endmodule : crtfr_video_timing

/* tb_crtfr_video_timing.sv */
// Self-checking bench for the raster timing and row fetch block
`timescale 1ns/100ps
module tb_crtfr_video_timing;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic frame_50hz_in = 1'b0;
  logic row_start_load_in = 1'b0;
  logic line_buffer_ready_in = 1'b1;
  logic [15:0] row_start_addr_in = 16'h0000;
  logic [7:0] host_delay = 8'h02;
  logic [7:0] ram_data_in;
  logic bus_grant_n_in, bus_request_n_out, nmi_n_out, addr_drive_en_out, grant_active_high_out;
  logic grant_active_low_buffered_out, ram_latch_output_en_out, temp_buffer_recirculate_out;
  logic line_rate_clock_n_out, row_strobe_n_out, address_mux_select_out, address_mux_select_inv_out;
  logic column_strobe_n_out, latch_transparent_out, delayed_buffer_clock_out;
  logic buffer_recirculate_enable_out, line_buffer_valid_out, line_buffer_is_char_out, hblank_out, hsync_out;
  logic [15:0] fetch_addr_out;
  logic [7:0] ram_latch_data_out, line_buffer_data_out;
  logic [3:0] scan_line_out;
  logic character_rate_clock_out;
  logic [4:0] row_out;
  int fails = 0;
  int cmp_count = 0;

  crtfr_video_timing #(.DATA_W(8)) i_dut (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .frame_50hz_in(frame_50hz_in),
    .bus_grant_n_in(bus_grant_n_in), .ram_data_in(ram_data_in), .row_start_addr_in(row_start_addr_in),
    .row_start_load_in(row_start_load_in), .line_buffer_ready_in(line_buffer_ready_in),
    .bus_request_n_out(bus_request_n_out), .nmi_n_out(nmi_n_out), .fetch_addr_out(fetch_addr_out),
    .addr_drive_en_out(addr_drive_en_out), .grant_active_high_out(grant_active_high_out),
    .grant_active_low_buffered_out(grant_active_low_buffered_out),
    .ram_latch_output_en_out(ram_latch_output_en_out), .temp_buffer_recirculate_out(temp_buffer_recirculate_out),
    .line_rate_clock_n_out(line_rate_clock_n_out), .character_rate_clock_out(character_rate_clock_out),
    .row_strobe_n_out(row_strobe_n_out), .address_mux_select_out(address_mux_select_out),
    .address_mux_select_inv_out(address_mux_select_inv_out), .column_strobe_n_out(column_strobe_n_out),
    .latch_transparent_out(latch_transparent_out), .ram_latch_data_out(ram_latch_data_out),
    .delayed_buffer_clock_out(delayed_buffer_clock_out),
    .buffer_recirculate_enable_out(buffer_recirculate_enable_out), .line_buffer_valid_out(line_buffer_valid_out),
    .line_buffer_data_out(line_buffer_data_out), .line_buffer_is_char_out(line_buffer_is_char_out),
    .hblank_out(hblank_out), .hsync_out(hsync_out), .vblank_out(), .vsync_out(),
    .scan_line_out(scan_line_out), .row_out(row_out)
  );

  crtfr_host_model i_host (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .bus_request_n_in(bus_request_n_out),
    .delay_in(host_delay), .bus_grant_n_out(bus_grant_n_in)
  );

  always #50 ref_clk_in = ~ref_clk_in;

  // ----------------------------------------------
  // Memory contents and helpers
  // ----------------------------------------------
  // Each byte depends on its whole address, so a skipped or repeated byte shows
  function automatic logic [7:0] ram_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction : ram_byte

  assign ram_data_in = ram_byte(fetch_addr_out);

  task automatic tick;
    @(posedge ref_clk_in);
    #1;
  endtask : tick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic pick(input int sel);
    case (sel)
      0: return hblank_out;
      1: return hsync_out;
      2: return nmi_n_out;
      3: return bus_request_n_out;
      4: return row_strobe_n_out;
      default: return line_rate_clock_n_out;
    endcase
  endfunction : pick

  // Counts clocks while the chosen output holds a level; capped so a stuck output cannot hang
  task automatic count_while(input int sel, input logic lvl, output int n);
    n = 0;
    while (pick(sel) === lvl && n < 20000) begin
      tick();
      n++;
    end
    if (n >= 20000) begin
      fails++;
      $display("[FAIL] %0t output stuck at one level", $time);
    end
  endtask : count_while

  // ----------------------------------------------
  // Scenarios
  // ----------------------------------------------
  task automatic t_horiz;
    int n;
    count_while(0, 1'b0, n);
    count_while(0, 1'b1, n);
    count_while(1, 1'b0, n);
    check(n, 567);
    count_while(1, 1'b1, n);
    check(n, 63);
    count_while(0, 1'b0, n);
    check(n, 90);
    count_while(0, 1'b1, n);
    check(n, 315);
  endtask : t_horiz

  task automatic t_fetch(input logic [15:0] start, input logic is_char, input logic [7:0] dly, input int stall);
    int n, got, cyc, pulses, early, t0, t1;
    host_delay = dly;
    count_while(2, 1'b1, n);
    count_while(2, 1'b0, n);
    check(n, 9);
    count_while(3, 1'b1, n);
    check(n + 9, 2070);
    check(scan_line_out, is_char ? 4'he : 4'h6);
    count_while(5, 1'b0, n);
    count_while(0, 1'b1, n);
    check(n, 35);
    check(row_out, 5'h00);
    check(buffer_recirculate_enable_out, !is_char);
    check({addr_drive_en_out, grant_active_high_out, ram_latch_output_en_out}, 3'h7);
    check({grant_active_low_buffered_out, temp_buffer_recirculate_out}, 2'h0);
    check(fetch_addr_out, start);
    check(character_rate_clock_out, 1'b1);
    count_while(4, 1'b1, n);
    check(n, 4);
    check(character_rate_clock_out, 1'b0);
    check(address_mux_select_out, 1'b1);
    tick();
    check({address_mux_select_out, latch_transparent_out}, 2'h1);
    tick();
    check(column_strobe_n_out, 1'b0);
    tick();
    check({row_strobe_n_out, address_mux_select_inv_out}, 2'h2);
    check(ram_latch_data_out, ram_byte(start));
    got = 0; cyc = 0; pulses = 0; early = 0; t0 = 0; t1 = 0;
    while (got < 80 && cyc < 3000) begin
      line_buffer_ready_in = !(cyc >= 60 && cyc < 60 + stall);
      if (line_buffer_ready_in && line_buffer_valid_out === 1'b1) begin
        check(line_buffer_data_out, ram_byte(start + 16'(got)));
        check(line_buffer_is_char_out, is_char);
        got++;
      end
      if (delayed_buffer_clock_out === 1'b0) begin
        pulses++;
        if (hblank_out !== 1'b0) early++;
        if (pulses == 1) t0 = cyc;
        if (pulses == 2) t1 = cyc;
      end
      tick();
      cyc++;
    end
    line_buffer_ready_in = 1'b1;
    check(got, 80);
    check(pulses, 80);
    check(early, 0);
    check(t1 - t0, 9);
    count_while(3, 1'b0, n);
    check(n < 20, 1'b1);
    repeat (3) tick();
    check(addr_drive_en_out, 1'b0);
  endtask : t_fetch

  // ----------------------------------------------
  // Main sequence and verdict
  // ----------------------------------------------
  task automatic results;
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    repeat (3) @(posedge ref_clk_in);
    #1;
    check(bus_request_n_out, 1'b1);
    check(scan_line_out, 4'h0);
    check(delayed_buffer_clock_out, 1'b1);
    reset_in = 1'b0;
    tick();
    row_start_addr_in = 16'h3120;
    row_start_load_in = 1'b1;
    tick();
    row_start_load_in = 1'b0;
    t_horiz();
    // Prompt host, receiver never stalls long enough to fill the buffer
    t_fetch(16'h3120, 1'b0, 8'h02, 0);
    // Character bytes start 80 below the enhancement bytes fetched above
    row_start_addr_in = 16'h30d0;
    row_start_load_in = 1'b1;
    tick();
    row_start_load_in = 1'b0;
    // Slow host and a long receiver stall that must hold the fetch back
    t_fetch(16'h30d0, 1'b1, 8'h28, 40);
    results();
  end

  // Two fetch rows take about 16000 clocks; allow roughly twice that
  initial begin
    #3000000;
    fails++;
    results();
  end
endmodule : tb_crtfr_video_timing
